// [shared/fapf_pkg.sv]
package fapf_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0]  ADDR_TIMEOUT_CFG = 4'h4;
	localparam logic [3:0]  ADDR_POWER_CTRL  = 4'h5;
	localparam logic [3:0]  ADDR_FILTER_CFG  = 4'h6;
	localparam logic [3:0]  ADDR_STATUS      = 4'h7;
	localparam int          DATA_W           = 24;

	// ----------------------------------------
	// fast_acquire_timeout_config fields
	// ----------------------------------------
	localparam int          TMO_LSB          = 0;
	localparam int          TMO_W            = 14;
	localparam int          FPC_LSB          = 14;
	localparam int          FPC_W            = 4;
	localparam int          CNT_W            = 15;
	localparam logic [13:0] TMO_MIN_COUNT    = 14'h0004;
	localparam logic [13:0] TMO_HIZ          = 14'h0000;
	localparam logic [13:0] TMO_ALWAYS_ON    = 14'h0001;
	localparam logic [13:0] TMO_DRIVE_LOW    = 14'h0002;
	localparam logic [13:0] TMO_DRIVE_HIGH   = 14'h0003;

	// ----------------------------------------
	// power_enable_control fields
	// ----------------------------------------
	localparam int          PWR_W            = 7;
	localparam int          PWR_LSB          = 0;
	localparam int          REG_RST_BIT      = 7;

	// ----------------------------------------
	// loop_filter_config fields
	// ----------------------------------------
	localparam int          CAP_LSB          = 0;
	localparam int          R3F_LSB          = 3;
	localparam int          R3_LSB           = 5;
	localparam int          R4F_LSB          = 7;
	localparam int          R4S_LSB          = 9;
	localparam int          FEN_BIT          = 11;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [13:0] RST_TMO          = 14'h0000;
	localparam logic [3:0]  RST_FPC          = 4'h0;
	localparam logic [6:0]  RST_PWR          = 7'h00;
	localparam logic [2:0]  RST_CAP          = 3'h0;
	localparam logic [1:0]  RST_RES          = 2'h0;
	localparam logic        RST_FEN          = 1'b0;

	// Capacitor selections: 0=50 pF, 1=100 pF, 2=150 pF
	localparam logic [1:0]  CAP_50           = 2'h0;
	localparam logic [1:0]  CAP_100          = 2'h1;
	localparam logic [1:0]  CAP_150          = 2'h2;

endpackage

// [verilog/fapf_ctrl.sv]
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps

module fapf_ctrl
	import fapf_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic [3:0]        addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [DATA_W-1:0] rdata,
	input  wire logic              pd_tick,
	input  wire logic              freq_write,
	input  wire logic [3:0]        steady_pump_current_code,
	output logic                   fast_acquire_pin_o,
	output logic                   fast_acquire_pin_oe,
	output logic                   fast_acquire_active,
	output logic [3:0]             pump_current_code,
	output logic [4:0]             pump_current_mult,
	output logic [1:0]             third_pole_resistor_sel,
	output logic [1:0]             fourth_pole_resistor_sel,
	output logic [1:0]             third_pole_cap_sel,
	output logic [1:0]             fourth_pole_cap_sel,
	output logic                   filter_poles_enable,
	output logic                   synth_loop_power_enable,
	output logic                   oscillator_core_power_enable,
	output logic                   reference_osc_power_enable,
	output logic                   oscillator_regulator_enable,
	output logic                   loop_regulator_one_enable,
	output logic                   loop_regulator_two_enable,
	output logic                   digital_regulator_enable
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic       rst_n;

	// Asserts at once; release waits for two clock edges so no flop sees a runt
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [13:0]      acquire_timeout_count_ff;
	logic [3:0]       fast_pump_current_code_ff;
	logic [PWR_W-1:0] power_en_ff;
	logic             reg_rst_ff;
	logic [2:0]       filter_capacitor_code_ff;
	logic [1:0]       third_pole_resistor_code_ff;
	logic [1:0]       third_pole_fast_resistor_code_ff;
	logic [1:0]       fourth_pole_resistor_code_ff;
	logic [1:0]       fourth_pole_fast_resistor_code_ff;
	logic             filter_poles_enable_ff;
	logic             wr_pwr;
	logic             soft_rst;
	logic             wr_ok;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Power writes stay open while the reset bit is held, so the release write lands
	assign wr_pwr   = wr_stb && (addr == ADDR_POWER_CTRL);
	assign soft_rst = wr_pwr && wdata[REG_RST_BIT];
	// Other registers stay at defaults while the reset bit is held
	assign wr_ok    = wr_stb && !reg_rst_ff && !soft_rst;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_en_ff <= RST_PWR;
			reg_rst_ff  <= 1'b0;
		end else if (wr_pwr) begin
			// Enables default off; the write that clears the reset bit also loads them
			reg_rst_ff  <= wdata[REG_RST_BIT];
			power_en_ff <= wdata[REG_RST_BIT] ? RST_PWR : wdata[PWR_LSB +: PWR_W];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acquire_timeout_count_ff  <= RST_TMO;
			fast_pump_current_code_ff <= RST_FPC;
		end else if (soft_rst) begin
			acquire_timeout_count_ff  <= RST_TMO;
			fast_pump_current_code_ff <= RST_FPC;
		end else if (wr_ok && addr == ADDR_TIMEOUT_CFG) begin
			acquire_timeout_count_ff  <= wdata[TMO_LSB +: TMO_W];
			fast_pump_current_code_ff <= wdata[FPC_LSB +: FPC_W];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			filter_capacitor_code_ff          <= RST_CAP;
			third_pole_fast_resistor_code_ff  <= RST_RES;
			third_pole_resistor_code_ff       <= RST_RES;
			fourth_pole_fast_resistor_code_ff <= RST_RES;
			fourth_pole_resistor_code_ff      <= RST_RES;
			filter_poles_enable_ff            <= RST_FEN;
		end else if (soft_rst) begin
			filter_capacitor_code_ff          <= RST_CAP;
			third_pole_fast_resistor_code_ff  <= RST_RES;
			third_pole_resistor_code_ff       <= RST_RES;
			fourth_pole_fast_resistor_code_ff <= RST_RES;
			fourth_pole_resistor_code_ff      <= RST_RES;
			filter_poles_enable_ff            <= RST_FEN;
		end else if (wr_ok && addr == ADDR_FILTER_CFG) begin
			filter_capacitor_code_ff          <= wdata[CAP_LSB +: 3];
			third_pole_fast_resistor_code_ff  <= wdata[R3F_LSB +: 2];
			third_pole_resistor_code_ff       <= wdata[R3_LSB +: 2];
			fourth_pole_fast_resistor_code_ff <= wdata[R4F_LSB +: 2];
			fourth_pole_resistor_code_ff      <= wdata[R4S_LSB +: 2];
			filter_poles_enable_ff            <= wdata[FEN_BIT];
		end
	end

	// ----------------------------------------
	// Timeout counter
	// ----------------------------------------
	logic [CNT_W-1:0] timeout_cnt_ff;
	logic             counting_ff;
	logic             count_mode;
	logic             fast_on;

	// Fifteen bits hold twice the largest field
	assign count_mode = (acquire_timeout_count_ff >= TMO_MIN_COUNT);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timeout_cnt_ff <= '0;
			counting_ff    <= 1'b0;
		end else if (soft_rst) begin
			// Register reset stops a running count on the same edge
			timeout_cnt_ff <= '0;
			counting_ff    <= 1'b0;
		end else if (!count_mode) begin
			// Small field values never start the count
			timeout_cnt_ff <= '0;
			counting_ff    <= 1'b0;
		end else if (freq_write) begin
			// Restart wins over a coincident tick
			timeout_cnt_ff <= {acquire_timeout_count_ff, 1'b0};
			counting_ff    <= 1'b1;
		end else if (counting_ff && pd_tick) begin
			timeout_cnt_ff <= timeout_cnt_ff - 15'h0001;
			if (timeout_cnt_ff == 15'h0001) begin
				counting_ff <= 1'b0;
			end
		end
	end

	// Gated by the field: lowering it to 0, 2 or 3 ends fast mode at once,
	// not one cycle later when the stale count flag clears
	assign fast_on = (counting_ff && count_mode) || (acquire_timeout_count_ff == TMO_ALWAYS_ON);

	// ----------------------------------------
	// Pin and steering
	// ----------------------------------------
	function automatic logic [1:0] cap_sel(input logic [2:0] code, input logic upper);
		logic [3:0] pair;
		pair = {CAP_50, CAP_150};
		unique case (code)
			3'h0: pair = {CAP_50, CAP_50};
			3'h1: pair = {CAP_50, CAP_100};
			3'h3: pair = {CAP_100, CAP_50};
			3'h4: pair = {CAP_150, CAP_50};
			3'h5: pair = {CAP_100, CAP_100};
			// Codes 2, 6 and 7 share one pair
			default: pair = {CAP_50, CAP_150};
		endcase
		return upper ? pair[3:2] : pair[1:0];
	endfunction

	logic       pin_o_ff;
	logic       pin_oe_ff;
	logic       nxt_pin_o;
	logic       nxt_pin_oe;

	always_comb begin
		nxt_pin_o  = 1'b0;
		nxt_pin_oe = 1'b0;
		unique case (acquire_timeout_count_ff)
			TMO_HIZ:        nxt_pin_oe = 1'b0;
			TMO_ALWAYS_ON:  nxt_pin_oe = 1'b1;
			TMO_DRIVE_LOW:  nxt_pin_oe = 1'b1;
			TMO_DRIVE_HIGH: begin
				nxt_pin_oe = 1'b1;
				nxt_pin_o  = 1'b1;
			end
			// Counting grounds the pin; idle leaves it released
			default:        nxt_pin_oe = counting_ff;
		endcase
	end

	logic [3:0] pump_ff;
	logic [1:0] r3_ff;
	logic [1:0] r4s_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_o_ff  <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else begin
			pin_o_ff  <= nxt_pin_o;
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	// Steering is registered: selections follow the mode one cycle late
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pump_ff   <= 4'h0;
			r3_ff     <= 2'h0;
			r4s_ff    <= 2'h0;
		end else begin
			pump_ff   <= fast_on ? fast_pump_current_code_ff : steady_pump_current_code;
			r3_ff     <= fast_on ? third_pole_fast_resistor_code_ff : third_pole_resistor_code_ff;
			r4s_ff    <= fast_on ? fourth_pole_fast_resistor_code_ff : fourth_pole_resistor_code_ff;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign fast_acquire_pin_o           = pin_o_ff;
	assign fast_acquire_pin_oe          = pin_oe_ff;
	assign fast_acquire_active          = fast_on;
	assign pump_current_code            = pump_ff;
	assign pump_current_mult            = {1'b0, pump_ff} + 5'h01;
	// Bypassed poles: resistors shorted, selections meaningless
	assign third_pole_resistor_sel      = r3_ff;
	assign fourth_pole_resistor_sel     = r4s_ff;
	assign third_pole_cap_sel           = cap_sel(filter_capacitor_code_ff, 1'b1);
	assign fourth_pole_cap_sel          = cap_sel(filter_capacitor_code_ff, 1'b0);
	assign filter_poles_enable          = filter_poles_enable_ff;
	assign synth_loop_power_enable      = power_en_ff[0];
	assign oscillator_core_power_enable = power_en_ff[1];
	assign reference_osc_power_enable   = power_en_ff[2];
	assign oscillator_regulator_enable  = power_en_ff[3];
	assign loop_regulator_one_enable    = power_en_ff[4];
	assign loop_regulator_two_enable    = power_en_ff[5];
	assign digital_regulator_enable     = power_en_ff[6];

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic [DATA_W-1:0] status_word;

	// Status: remaining count above the fast-mode flag, read only
	assign status_word = {8'h00, timeout_cnt_ff, fast_on};

	// Fields read back where they were written
	always_comb begin
		nxt_rdata = '0;
		unique case (addr)
			ADDR_TIMEOUT_CFG: nxt_rdata = {6'h00, fast_pump_current_code_ff, acquire_timeout_count_ff};
			ADDR_POWER_CTRL:  nxt_rdata = {16'h0000, reg_rst_ff, power_en_ff};
			ADDR_FILTER_CFG:  nxt_rdata = {12'h000, filter_poles_enable_ff, fourth_pole_resistor_code_ff,
				fourth_pole_fast_resistor_code_ff, third_pole_resistor_code_ff,
				third_pole_fast_resistor_code_ff, filter_capacitor_code_ff};
			ADDR_STATUS:      nxt_rdata = status_word;
			default:          nxt_rdata = '0;
		endcase
	end

	// Data stand in each cycle that follows a strobed cycle; zero otherwise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= rd_stb ? nxt_rdata : '0;
		end
	end
	assign rdata = rdata_ff;

endmodule

// [tb/fapf_ctrl_properties.sv]
`timescale 1ns/1ps

module fapf_ctrl_properties
	import fapf_pkg::*;
(
	input wire logic              clock,
	input wire logic              nrst,
	input wire logic [3:0]        addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic              pd_tick,
	input wire logic              freq_write,
	input wire logic              fast_acquire_pin_o,
	input wire logic              fast_acquire_pin_oe,
	input wire logic              fast_acquire_active,
	input wire logic [3:0]        pump_current_code,
	input wire logic [4:0]        pump_current_mult,
	input wire logic [1:0]        third_pole_cap_sel,
	input wire logic [1:0]        fourth_pole_cap_sel,
	input wire logic              synth_loop_power_enable,
	input wire logic              digital_regulator_enable
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking dcb @(posedge clock); endclocking
	default disable iff (!nrst);

	AST_MULT: assert property (pump_current_mult == {1'b0, pump_current_code} + 5'h01)
		else $error("pump multiple wrong");
	AST_PIN_GROUNDED: assert property (fast_acquire_active ##1 fast_acquire_active |->
		fast_acquire_pin_oe && !fast_acquire_pin_o) else $error("pin not grounded in fast mode");
	AST_PIN_HIGH: assert property (fast_acquire_pin_o |-> !$past(fast_acquire_active))
		else $error("pin high during fast mode");
	AST_IDLE_STAYS: assert property (!fast_acquire_active && !freq_write && !wr_stb |=>
		!fast_acquire_active) else $error("fast mode without cause");
	AST_COUNT_HOLDS: assert property (fast_acquire_active && !pd_tick && !wr_stb |=>
		fast_acquire_active) else $error("count ended without tick");
	AST_RDATA_ZERO: assert property (!rd_stb |=> rdata == '0)
		else $error("read data outside answer cycle");
	AST_CAP_PAIR: assert property (third_pole_cap_sel != 2'h3 && fourth_pole_cap_sel != 2'h3 &&
		!(third_pole_cap_sel != CAP_50 && fourth_pole_cap_sel == CAP_150) &&
		!(third_pole_cap_sel == CAP_150 && fourth_pole_cap_sel != CAP_50)) else $error("bad cap pair");
	AST_SOFT_RESET: assert property (wr_stb && addr == ADDR_POWER_CTRL && wdata[REG_RST_BIT] |=>
		##1 !synth_loop_power_enable && !digital_regulator_enable && !fast_acquire_active)
		else $error("soft reset left part powered");

	cover property (freq_write ##1 fast_acquire_active);
	cover property ($fell(fast_acquire_active));
	cover property (rd_stb ##1 rdata != '0);
endmodule

bind fapf_ctrl fapf_ctrl_properties u_props (
	.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata(rdata), .pd_tick(pd_tick), .freq_write(freq_write), .fast_acquire_pin_o(fast_acquire_pin_o),
	.fast_acquire_pin_oe(fast_acquire_pin_oe), .fast_acquire_active(fast_acquire_active),
	.pump_current_code(pump_current_code), .pump_current_mult(pump_current_mult),
	.third_pole_cap_sel(third_pole_cap_sel), .fourth_pole_cap_sel(fourth_pole_cap_sel),
	.synth_loop_power_enable(synth_loop_power_enable), .digital_regulator_enable(digital_regulator_enable)
);

// [tb/fapf_ctrl_tb.sv]
`timescale 1ns/1ps

module fapf_ctrl_tb
	import fapf_pkg::*;
;
	logic              clock, nrst, wr_stb, rd_stb, pd_tick, freq_write, pin_o, pin_oe, active, fen;
	logic [3:0]        addr, steady, pump;
	logic [DATA_W-1:0] wdata, rdata;
	logic [4:0]        mult;
	logic [1:0]        r3, r4s, c3, c4;
	logic [6:0]        pwr;
	logic [1:0]        c3_tab [8];
	logic [1:0]        c4_tab [8];
	int                error_cnt, n_tests, seed, m_tmo, m_fpc, m_pwr, m_flt, m_rst, cnt, i, k;

	fapf_ctrl dut (
		.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .pd_tick(pd_tick), .freq_write(freq_write), .steady_pump_current_code(steady),
		.fast_acquire_pin_o(pin_o), .fast_acquire_pin_oe(pin_oe), .fast_acquire_active(active),
		.pump_current_code(pump), .pump_current_mult(mult), .third_pole_resistor_sel(r3),
		.fourth_pole_resistor_sel(r4s), .third_pole_cap_sel(c3), .fourth_pole_cap_sel(c4),
		.filter_poles_enable(fen), .synth_loop_power_enable(pwr[0]), .oscillator_core_power_enable(pwr[1]),
		.reference_osc_power_enable(pwr[2]), .oscillator_regulator_enable(pwr[3]),
		.loop_regulator_one_enable(pwr[4]), .loop_regulator_two_enable(pwr[5]), .digital_regulator_enable(pwr[6])
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input int d);
		@(posedge clock);
		addr <= a;
		wdata <= d[23:0];
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		if (a == ADDR_POWER_CTRL) begin
			m_rst = d[7];
			m_pwr = d[7] ? 0 : d[6:0];
			if (d[7]) begin
				m_tmo = 0;
				m_fpc = 0;
				m_flt = 0;
				cnt = 0;
			end
		end else if (a == ADDR_TIMEOUT_CFG && !m_rst) begin
			m_tmo = d[13:0];
			m_fpc = d[17:14];
			if (m_tmo < 4) cnt = 0;
		end else if (a == ADDR_FILTER_CFG && !m_rst)
			m_flt = d[11:0];
	endtask

	task automatic rd(input logic [3:0] a, input int e);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 chk(rdata, e[23:0]);
	endtask

	// One-cycle frequency write or phase-detector tick
	task automatic pulse(input bit f);
		@(posedge clock);
		if (f) freq_write <= 1'b1;
		else pd_tick <= 1'b1;
		@(posedge clock);
		freq_write <= 1'b0;
		pd_tick <= 1'b0;
		if (f && m_tmo >= 4) cnt = 2 * m_tmo;
		else if (!f && cnt > 0) cnt--;
		#1;
	endtask

	task automatic chk_out;
		bit f;
		f = (cnt > 0) || (m_tmo == 1);
		chk(active, f);
		chk(pin_oe, m_tmo == 0 ? 0 : m_tmo < 4 ? 1 : f);
		chk(pin_o, m_tmo == 3);
		chk(pump, f ? m_fpc : steady);
		chk(mult, (f ? m_fpc : steady) + 1);
		chk(r3, f ? m_flt[4:3] : m_flt[6:5]);
		chk(r4s, f ? m_flt[8:7] : m_flt[10:9]);
		chk({c3, c4}, {c3_tab[m_flt[2:0]], c4_tab[m_flt[2:0]]});
		chk(fen, m_flt[11]);
		chk(pwr, m_pwr);
	endtask

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		test_done;
	end

	initial begin
		c3_tab = '{CAP_50, CAP_50, CAP_50, CAP_100, CAP_150, CAP_100, CAP_50, CAP_50};
		c4_tab = '{CAP_50, CAP_100, CAP_150, CAP_50, CAP_50, CAP_100, CAP_150, CAP_150};
		seed = 70;
		nrst = 1'b0;
		{addr, wdata, wr_stb, rd_stb, pd_tick, freq_write, steady} = '0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		cyc(4);
		chk_out;
		rd(4'h2, 0);
		rd(ADDR_STATUS, 0);
		// Two-write start-up, then two random enable sets, then all on
		wr(ADDR_POWER_CTRL, 'h80);
		wr(ADDR_POWER_CTRL, 0);
		for (i = 0; i < 3; i++) begin
			wr(ADDR_POWER_CTRL, i == 2 ? 'h7f : $random(seed) & 'h7f);
			cyc(2);
			chk_out;
			rd(ADDR_POWER_CTRL, m_pwr);
		end
		for (k = 0; k < 4; k++) begin
			@(posedge clock) steady <= 4'($random(seed));
			wr(ADDR_TIMEOUT_CFG, k | ($random(seed) & 'hf) << 14);
			pulse(1);
			cyc(2);
			chk_out;
			rd(ADDR_TIMEOUT_CFG, m_tmo | m_fpc << 14);
		end
		for (k = 0; k < 8; k++) begin
			wr(ADDR_FILTER_CFG, k | $random(seed) & 'hff8);
			cyc(2);
			chk_out;
			rd(ADDR_FILTER_CFG, m_flt);
		end
		// Shortest count, restarted mid-way
		wr(ADDR_TIMEOUT_CFG, 4 | 'ha << 14);
		pulse(0);
		cyc(2);
		chk_out;
		pulse(1);
		chk(active, 1);
		cyc(1);
		chk_out;
		for (i = 0; i < 5; i++) pulse(0);
		rd(ADDR_STATUS, 1 | cnt << 1);
		pulse(1);
		for (i = 0; i < 8; i++) begin
			pulse(0);
			chk(active, cnt > 0);
		end
		chk(pin_oe, 1);
		cyc(1);
		chk_out;
		wr(ADDR_TIMEOUT_CFG, 16383);
		pulse(1);
		rd(ADDR_STATUS, 1 | cnt << 1);
		// Soft reset in mid-count blocks other writes
		wr(ADDR_POWER_CTRL, 'h80);
		wr(ADDR_TIMEOUT_CFG, 7);
		wr(ADDR_FILTER_CFG, 'hfff);
		cyc(2);
		chk_out;
		rd(ADDR_TIMEOUT_CFG, 0);
		rd(ADDR_FILTER_CFG, 0);
		test_done;
	end
endmodule
